// ===== rtl/lor_defs.svh
// Opcode, bit position and reset value constants for the OR execution unit
`ifndef LOR_DEFS_SVH
`define LOR_DEFS_SVH
`define LOR_OP_IND_HI    7'h23
`define LOR_OP_REG_HI    5'h09
`define LOR_OP_DIR       8'h45
`define LOR_OP_BIT       8'h72
`define LOR_OP_NBIT      8'ha0
`define LOR_OP_IMM_MEM   8'h43
`define LOR_OP_ACC_MEM   8'h42
`define LOR_ACC_RST      8'h00
`define LOR_CY_BIT       7
`define LOR_P_BIT        0
`define LOR_PSW_RST      8'h00
`endif

// ===== rtl/lor_pkg.sv
// Types for the OR execution unit
package lor_pkg;
    typedef enum logic [2:0] {
        LOR_IDLE,
        LOR_RDMEM,
        LOR_EXEC,
        LOR_BITRD,
        LOR_BITEX
    } lor_state_t;
endpackage

// ===== rtl/lor_exec.sv
// OR instruction family execution unit
//
// Contract
// RULE1: Opcode 0100011r ORs via working register 0 or 1 in one cycle; the code raises done_ff three cycles after accepting it.
// RULE2: The indirect form ORs memory at the register value into acc.
// RULE3: Every byte OR sets each result bit when either operand bit is 1.
// RULE4: Opcode 01001rrr ORs working register rrr into acc in one cycle.
// RULE5: Opcode 01000101 plus an address ORs that byte into acc.
// RULE6: Opcode 01110010 plus a bit address ORs the bit into carry.
// RULE7: Opcode 10100000 plus a bit address ORs the inverted bit into carry.
// RULE8: The complemented bit form never writes the addressed bit.
// RULE9: Opcode 01000011 plus address and immediate writes their OR back.
// RULE10: The acc-to-memory form writes memory OR acc, acc unchanged.
// RULE11: The acc-to-memory form is opcode 01000010 plus an address byte.
// RULE12: Acc writes update parity; only the bit forms alter carry.
`timescale 1ns/1ps
`include "lor_defs.svh"
module lor_exec (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic       clk_en,
    // Instruction in
    input  wire logic       ins_valid,
    input  wire logic [7:0] ins_op,
    input  wire logic [7:0] ins_b1,
    input  wire logic [7:0] ins_b2,
    // Working registers and memory read data
    input  wire logic [7:0] working_register [8],
    input  wire logic [7:0] mem_rdata,
    // Memory port
    output logic            mem_re_ff,
    output logic            mem_we_ff,
    output logic [7:0]      mem_addr_ff,
    output logic [7:0]      mem_wdata_ff,
    // Status
    output logic [7:0]      acc_ff,
    output logic [7:0]      program_status_word_ff,
    output logic            busy_ff,
    output logic            done_ff
);
    // ==========================================================
    // Reset release
    logic rst_s1_ff;
    logic rst_n_ff;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rst_s1_ff <= 1'b0;
            rst_n_ff  <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_n_ff  <= rst_s1_ff;
        end
    end

    // ==========================================================
    // Execution state
    lor_pkg::lor_state_t state_ff, nxt_state;
    logic [7:0] op_ff, nxt_op;
    logic [7:0] imm_ff, nxt_imm;
    logic [2:0] bitsel_ff, nxt_bitsel;
    logic [7:0] nxt_acc, nxt_psw, nxt_addr, nxt_wdata;
    logic       nxt_re, nxt_we, nxt_busy, nxt_done;
    logic [7:0] res;
    logic       sel_bit;

    always_comb begin
        nxt_state  = state_ff;
        nxt_op     = op_ff;
        nxt_imm    = imm_ff;
        nxt_bitsel = bitsel_ff;
        nxt_acc    = acc_ff;
        nxt_psw    = program_status_word_ff;
        nxt_addr   = mem_addr_ff;
        nxt_wdata  = mem_wdata_ff;
        nxt_re     = 1'b0;
        nxt_we     = 1'b0;
        nxt_busy   = busy_ff;
        nxt_done   = 1'b0;
        res        = 8'h00;
        sel_bit    = 1'b0;
        case (state_ff)
            lor_pkg::LOR_IDLE: begin
                if (ins_valid) begin
                    nxt_op = ins_op;
                    nxt_imm = ins_b2;
                    if (ins_op[7:3] == `LOR_OP_REG_HI) begin
                        // Register operand is at hand: finish now
                        res = acc_ff | working_register[ins_op[2:0]]; // RULE3
                        nxt_acc = res; // RULE4
                        nxt_psw[`LOR_P_BIT] = ^res; // RULE12
                        nxt_done = 1'b1;
                    end else if (ins_op[7:1] == `LOR_OP_IND_HI) begin
                        nxt_addr = working_register[{2'b00, ins_op[0]}]; // RULE1 RULE2
                        nxt_re = 1'b1;
                        nxt_busy = 1'b1;
                        nxt_state = lor_pkg::LOR_RDMEM;
                    end else if (ins_op == `LOR_OP_DIR || // RULE5
                                 ins_op == `LOR_OP_IMM_MEM || // RULE9
                                 ins_op == `LOR_OP_ACC_MEM) begin // RULE11
                        nxt_addr = ins_b1;
                        nxt_re = 1'b1;
                        nxt_busy = 1'b1;
                        nxt_state = lor_pkg::LOR_RDMEM;
                    end else if (ins_op == `LOR_OP_BIT ||
                                 ins_op == `LOR_OP_NBIT) begin // RULE6 RULE7
                        // Bit space maps low half to bytes 20h..2fh,
                        // high half to byte-aligned special registers
                        nxt_addr = ins_b1[7] ? {ins_b1[7:3], 3'b000}
                                             : {4'h2, ins_b1[6:3]};
                        nxt_bitsel = ins_b1[2:0];
                        nxt_re = 1'b1;
                        nxt_busy = 1'b1;
                        nxt_state = lor_pkg::LOR_BITRD;
                    end else begin
                        nxt_done = 1'b1;
                    end
                end
            end
            lor_pkg::LOR_RDMEM: begin
                nxt_state = lor_pkg::LOR_EXEC;
            end
            lor_pkg::LOR_EXEC: begin
                if (op_ff == `LOR_OP_IMM_MEM) begin
                    nxt_wdata = mem_rdata | imm_ff; // RULE9 RULE3
                    nxt_we = 1'b1;
                end else if (op_ff == `LOR_OP_ACC_MEM) begin
                    // Accumulator and parity stay as they are
                    nxt_wdata = mem_rdata | acc_ff; // RULE10 RULE3
                    nxt_we = 1'b1;
                end else begin
                    res = acc_ff | mem_rdata; // RULE2 RULE3 RULE5
                    nxt_acc = res;
                    nxt_psw[`LOR_P_BIT] = ^res; // RULE12
                end
                nxt_busy = 1'b0;
                nxt_done = 1'b1;
                nxt_state = lor_pkg::LOR_IDLE;
            end
            lor_pkg::LOR_BITRD: begin
                nxt_state = lor_pkg::LOR_BITEX;
            end
            lor_pkg::LOR_BITEX: begin
                // Read only: the addressed bit is never written back
                sel_bit = mem_rdata[bitsel_ff]; // RULE8
                if (op_ff == `LOR_OP_NBIT)
                    nxt_psw[`LOR_CY_BIT] =
                        program_status_word_ff[`LOR_CY_BIT] | ~sel_bit; // RULE7
                else
                    nxt_psw[`LOR_CY_BIT] =
                        program_status_word_ff[`LOR_CY_BIT] | sel_bit; // RULE6
                nxt_busy = 1'b0;
                nxt_done = 1'b1;
                nxt_state = lor_pkg::LOR_IDLE;
            end
            default: begin
                nxt_state = lor_pkg::LOR_IDLE;
                nxt_busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            state_ff               <= lor_pkg::LOR_IDLE;
            op_ff                  <= 8'h00;
            imm_ff                 <= 8'h00;
            bitsel_ff              <= 3'h0;
            acc_ff                 <= `LOR_ACC_RST;
            program_status_word_ff <= `LOR_PSW_RST;
            mem_addr_ff            <= 8'h00;
            mem_wdata_ff           <= 8'h00;
            mem_re_ff              <= 1'b0;
            mem_we_ff              <= 1'b0;
            busy_ff                <= 1'b0;
            done_ff                <= 1'b0;
        end else if (clk_en) begin
            state_ff               <= nxt_state;
            op_ff                  <= nxt_op;
            imm_ff                 <= nxt_imm;
            bitsel_ff              <= nxt_bitsel;
            acc_ff                 <= nxt_acc;
            program_status_word_ff <= nxt_psw;
            mem_addr_ff            <= nxt_addr;
            mem_wdata_ff           <= nxt_wdata;
            mem_re_ff              <= nxt_re;
            mem_we_ff              <= nxt_we;
            busy_ff                <= nxt_busy;
            done_ff                <= nxt_done;
        end
    end
endmodule

// ===== sim/lor_exec_chk.sv
// Assertion checker for the OR execution unit
`timescale 1ns/1ps
module lor_exec_chk (
    // Clock, reset and request
    input wire logic       clk_sys,
    input wire logic       resetn,
    input wire logic       clk_en,
    input wire logic       ins_valid,
    input wire logic [7:0] ins_op,
    input wire logic [7:0] ins_b1,
    input wire logic [7:0] ins_b2,
    input wire logic [7:0] working_register [8],
    input wire logic [7:0] mem_rdata,
    // Results
    input wire logic       mem_re_ff,
    input wire logic       mem_we_ff,
    input wire logic [7:0] mem_addr_ff,
    input wire logic [7:0] mem_wdata_ff,
    input wire logic [7:0] acc_ff,
    input wire logic [7:0] program_status_word_ff,
    input wire logic       busy_ff,
    input wire logic       done_ff
);
    wire tk = clk_en && ins_valid && !busy_ff;
    // =========================================
    // Properties; a frozen clock enable disables them
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn || !clk_en);
    reg_or_a: assert property (tk && ins_op[7:3] == 5'h09
        |=> done_ff && acc_ff == ($past(acc_ff)
            | $past(working_register[ins_op[2:0]])))
        else $error("register form result wrong");
    parity_a: assert property (program_status_word_ff[0] == ^acc_ff)
        else $error("parity flag wrong");
    ind_addr_a: assert property (tk && ins_op[7:1] == 7'h23
        |=> mem_re_ff && mem_addr_ff == $past(working_register[ins_op[0]]))
        else $error("indirect address wrong");
    mem_acc_a: assert property (
        tk && (ins_op == 8'h45 || ins_op[7:1] == 7'h23)
        |=> mem_re_ff ##2 done_ff
            && acc_ff == ($past(acc_ff, 3) | $past(mem_rdata)))
        else $error("memory to accumulator result wrong");
    imm_mem_a: assert property (
        tk && ins_op == 8'h43 |=> mem_re_ff ##2 mem_we_ff
        && mem_addr_ff == $past(ins_b1, 3)
        && mem_wdata_ff == ($past(mem_rdata) | $past(ins_b2, 3)))
        else $error("immediate to memory write wrong");
    acc_mem_a: assert property (
        tk && ins_op == 8'h42 |-> ##3 mem_we_ff
        && acc_ff == $past(acc_ff, 3)
        && mem_wdata_ff == ($past(mem_rdata) | $past(acc_ff, 3)))
        else $error("accumulator to memory write wrong");
    bit_or_a: assert property (
        tk && (ins_op == 8'h72 || ins_op == 8'ha0)
        |=> !mem_we_ff [*3] ##0 done_ff
        && program_status_word_ff[7] ==
           ($past(program_status_word_ff[7], 3)
            | ((|(($past(mem_rdata) >> $past(ins_b1[2:0], 3)) & 8'h01))
               ^ ($past(ins_op, 3) == 8'ha0))))
        else $error("bit form carry wrong");
    carry_keep_a: assert property ($changed(program_status_word_ff[7])
        |-> $past(tk && (ins_op == 8'h72 || ins_op == 8'ha0), 3))
        else $error("carry changed by a byte form");
endmodule
bind lor_exec lor_exec_chk chk (.*);

// ===== sim/lor_exec_bench.sv
// Self-checking bench for the OR execution unit
`timescale 1ns/1ps
module lor_exec_bench;
    logic       clk_sys = 1'b0, resetn = 1'b0, clk_en = 1'b1, ins_valid = 1'b0;
    logic       mem_re_ff, mem_we_ff, busy_ff, done_ff;
    logic [7:0] ins_op = 8'h00, ins_b1 = 8'h00, ins_b2 = 8'h00;
    logic [7:0] mem_rdata = 8'h00, mem_addr_ff, mem_wdata_ff, acc_ff;
    logic [7:0] program_status_word_ff;
    logic [7:0] working_register [8] = '{default: 8'h00};
    logic [7:0] mem [256];
    int         fails = 0, check_count = 0, cyc = 0;
    lor_exec DUT (.*);
    always #20 clk_sys = ~clk_sys;
    // =========================================
    // Memory answers one cycle after a read; otherwise its data churns
    always @(posedge clk_sys) begin
        mem_rdata <= #1 mem_re_ff ? mem[mem_addr_ff] : ~mem_rdata;
        if (mem_we_ff) mem[mem_addr_ff] <= mem_wdata_ff;
        cyc++;
        if (cyc == 3000) begin
            fails++;
            tally_and_finish();
        end
    end
    task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s: expected %h, seen %h", nm, exp, got);
        end
    endtask
    task automatic rst();
        resetn = 1'b0;
        repeat (4) @(posedge clk_sys);
        #1 resetn = 1'b1;
        repeat (3) @(posedge clk_sys);
    endtask
    // Single request, then wait for completion and let a write land
    task automatic issue(logic [7:0] op, logic [7:0] b1, logic [7:0] b2);
        int n = 0;
        @(posedge clk_sys) #1;
        {ins_valid, ins_op, ins_b1, ins_b2} = {1'b1, op, b1, b2};
        @(posedge clk_sys) #1;
        ins_valid = 1'b0;
        while (done_ff !== 1'b1 && n < 6) begin
            @(posedge clk_sys) #1;
            n++;
        end
        chk("done", 8'h01, {7'h00, done_ff});
        @(posedge clk_sys) #1;
    endtask
    task automatic t_reg();
        for (int r = 0; r < 8; r++) working_register[r] = 8'h01 << r;
        @(posedge clk_sys) #1;
        ins_valid = 1'b1;
        for (int r = 0; r < 8; r++) begin
            ins_op = {5'h09, 3'(r)};
            @(posedge clk_sys) #1;
        end
        ins_valid = 1'b0;
        chk("acc", 8'hff, acc_ff);
        chk("psw", 8'h00, program_status_word_ff);
    endtask
    task automatic t_bytes();
        {working_register[4], working_register[1]} = {8'h28, 8'h52};
        {mem[8'h52], mem[8'h37], mem[8'h57], mem[8'h10]} = 32'h01807631;
        issue(8'h4c, 8'h00, 8'h00);
        issue(8'h47, 8'h00, 8'h00);
        chk("acc", 8'h29, acc_ff);
        chk("psw", 8'h01, program_status_word_ff);
        issue(8'h45, 8'h37, 8'h00);
        chk("acc", 8'ha9, acc_ff);
        issue(8'h43, 8'h57, 8'h01);
        chk("mem", 8'h77, mem[8'h57]);
        issue(8'h42, 8'h10, 8'h00);
        chk("mem", 8'hb9, mem[8'h10]);
        chk("acc", 8'ha9, acc_ff);
    endtask
    task automatic t_bits();
        {mem[8'h25], mem[8'h26]} = 16'h0626;
        issue(8'ha0, 8'h2a, 8'h00);
        chk("psw", 8'h00, program_status_word_ff);
        issue(8'ha0, 8'h2d, 8'h00);
        chk("psw", 8'h80, program_status_word_ff);
        chk("mem", 8'h06, mem[8'h25]);
        rst();
        issue(8'h72, 8'h30, 8'h00);
        chk("psw", 8'h00, program_status_word_ff);
        issue(8'h72, 8'h32, 8'h00);
        chk("psw", 8'h80, program_status_word_ff);
    endtask
    // Frozen enable must hold a pending register form back
    task automatic t_freeze();
        @(posedge clk_sys) #1;
        {clk_en, ins_valid, ins_op} = {1'b0, 1'b1, 8'h49};
        repeat (2) @(posedge clk_sys);
        #1;
        chk("acc", 8'h00, acc_ff);
        chk("done", 8'h00, {7'h00, done_ff});
        clk_en = 1'b1;
        @(posedge clk_sys) #1;
        ins_valid = 1'b0;
        chk("acc", 8'h52, acc_ff);
        chk("psw", 8'h81, program_status_word_ff);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        rst();
        t_reg();
        rst();
        t_bytes();
        t_bits();
        t_freeze();
        tally_and_finish();
    end
endmodule
